// *** rtl/pspm_pkg.sv ***
// package for the switch power management block
// assumes one core clock and synchronous active-high reset
package pspm_pkg;

  // power state field encodings
  localparam logic [1:0] PS_D0    = 2'h0;
  localparam logic [1:0] PS_D3HOT = 2'h3;

  // no soft reset default: context is kept across d3hot
  localparam logic NO_SOFT_RESET_DEFAULT = 1'h1;

  // function power state
  typedef enum logic [1:0] {
    PSPM_D0_UNINIT = 2'b00,
    PSPM_D0_ACTIVE = 2'b01,
    PSPM_D3_HOT    = 2'b10
  } pspm_fstate_t;

  // link state requests
  typedef enum logic [1:0] {
    PSPM_L0    = 2'b00,
    PSPM_L1    = 2'b01,
    PSPM_L2RDY = 2'b10
  } pspm_link_t;

  // fence aggregation states
  typedef enum logic [1:0] {
    PSPM_AG_IDLE = 2'b00,
    PSPM_AG_WAIT = 2'b01,
    PSPM_AG_DONE = 2'b10,
    PSPM_AG_ABAN = 2'b11
  } pspm_agg_t;

  // received request classification on the bridge
  typedef struct packed {
    logic valid;
    logic primary;    // arrived on the primary side
    logic cfg_type0;
    logic message;
    logic to_self;    // targets the bridge function
    logic completion;
  } pspm_req_t;

  // disposition of a request
  typedef struct packed {
    logic accept;
    logic unsupported;
    logic unexpected_cpl;
    logic route;
  } pspm_disp_t;

endpackage : pspm_pkg

// *** rtl/pspm_func.sv ***
// one bridge function power state machine with request handling in d3hot
// assumes config writes and classified requests arrive on the core clock
module pspm_func
  import pspm_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         srst,
  input  wire logic         cfg_done,
  input  wire logic         ps_write,
  input  wire logic [1:0]   ps_wdata,
  input  wire pspm_req_t    req,
  output pspm_fstate_t      fstate,
  output logic [1:0]        power_state_field,
  output logic              no_soft_reset_flag,
  output pspm_disp_t        disp
);

  pspm_fstate_t next_fstate;
  wire logic    in_d3 = (fstate == PSPM_D3_HOT);

  // state transitions from config writes; unsupported codes ignored
  always_comb
  begin
    next_fstate = fstate;
    case (fstate)
      PSPM_D0_UNINIT: if (ps_write && ps_wdata == PS_D3HOT) next_fstate = PSPM_D3_HOT;
                      else if (cfg_done) next_fstate = PSPM_D0_ACTIVE;
      PSPM_D0_ACTIVE: if (ps_write && ps_wdata == PS_D3HOT) next_fstate = PSPM_D3_HOT;
      PSPM_D3_HOT:    if (ps_write && ps_wdata == PS_D0) next_fstate = PSPM_D0_UNINIT;
      default:        next_fstate = PSPM_D0_UNINIT;
    endcase
  end

  // partition reset returns to d0 uninitialized; d3 exit also returns to d0 uninitialized
  always_ff @(posedge clock)
  begin
    if (srst)
      fstate <= PSPM_D0_UNINIT;
    else
      fstate <= next_fstate;
  end

  assign power_state_field  = in_d3 ? PS_D3HOT : PS_D0;
  assign no_soft_reset_flag = NO_SOFT_RESET_DEFAULT;

  // request disposition: d3hot limits what the bridge serves
  wire logic ok_d3 = req.primary && (req.cfg_type0 || (req.message && req.to_self));
  wire logic is_cpl_self = req.completion && req.to_self;
  wire logic unexp_cpl   = req.valid && in_d3 && is_cpl_self;
  wire logic route_cpl   = req.valid && req.completion && !req.to_self;
  wire logic acc_req     = req.valid && !req.completion && (!in_d3 || ok_d3);
  wire logic unsup_req   = req.valid && in_d3 && !req.completion && !ok_d3;

  // one driver for the whole disposition word
  assign disp = '{accept: acc_req, unsupported: unsup_req, unexpected_cpl: unexp_cpl, route: route_cpl};

  AST_D3_EXIT: assert property (@(posedge clock) disable iff (srst)
    (fstate == PSPM_D3_HOT && ps_write && ps_wdata == PS_D0) |=> fstate == PSPM_D0_UNINIT)
    else $error("d3hot exit did not reach d0 uninitialized");
  AST_BAD_CODE: assert property (@(posedge clock) disable iff (srst)
    (fstate == PSPM_D3_HOT && ps_write && ps_wdata != PS_D0) |=> fstate == PSPM_D3_HOT)
    else $error("unsupported power code changed state");
  AST_SEC_UR: assert property (@(posedge clock) disable iff (srst)
    (in_d3 && req.valid && !req.primary && !req.completion) |-> disp.unsupported)
    else $error("secondary request in d3hot not unsupported");

endmodule : pspm_func

// *** rtl/pspm_top.sv ***
// switch partition power management: functions, link requests, fence protocol
// assumes link layers report fence messages and link states as core-clock pulses and levels
module pspm_top
  import pspm_pkg::*;
#(
  parameter int NDS = 4
)
(
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic [NDS:0]     cfg_done,
  input  wire logic [NDS:0]     ps_write,
  input  wire logic [1:0]       ps_wdata,
  input  wire pspm_req_t        req [NDS:0],
  input  wire logic             other_partitions_low,
  input  wire logic             partition_enabled,
  input  wire logic [NDS-1:0]   ds_active,
  input  wire logic [NDS-1:0]   ds_partner_l1_req,
  input  wire logic [NDS-1:0]   ds_hp_event,
  input  wire logic [NDS-1:0]   ds_pme_enable,
  input  wire logic [NDS:0]     err_valid,
  input  wire logic [NDS:0]     err_from_tlp,
  input  wire logic [NDS:0]     err_report_en,
  input  wire logic [NDS-1:0]   ds_cpl_tx,
  input  wire logic [NDS-1:0]   ds_tlp_tx,
  input  wire logic [NDS-1:0]   ds_link_l0,
  input  wire logic             us_turn_off_rx,
  input  wire logic [NDS-1:0]   ds_ack_rx,
  input  wire logic             us_tlp_rx,
  input  wire logic             us_tlp_to_self,
  output pspm_fstate_t          fstate [NDS:0],
  output logic [1:0]            power_state_field [NDS:0],
  output logic [NDS:0]          no_soft_reset_flag,
  output pspm_disp_t            disp [NDS:0],
  output pspm_link_t            link_req [NDS:0],
  output logic [NDS-1:0]        ds_l1_accept,
  output logic [NDS:0]          err_msg_send,
  output logic [NDS-1:0]        pme_send,
  output logic [NDS-1:0]        turn_off_tx,
  output logic                  us_ack_tx,
  output logic                  us_tlp_drop,
  output logic [NDS-1:0]        ds_retrain,
  output logic                  partition_low,
  output logic                  device_low
);

  // index 0 is the upstream bridge, 1..NDS the downstream bridges
  genvar gi;
  for (gi = 0; gi <= NDS; gi++)
  begin : g_fn
    pspm_func u_fn (
      .clock              (clock),
      .srst               (srst),
      .cfg_done           (cfg_done[gi]),
      .ps_write           (ps_write[gi]),
      .ps_wdata           (ps_wdata),
      .req                (req[gi]),
      .fstate             (fstate[gi]),
      .power_state_field  (power_state_field[gi]),
      .no_soft_reset_flag (no_soft_reset_flag[gi]),
      .disp               (disp[gi])
    );
  end

  // fence aggregation
  pspm_agg_t       agg;
  pspm_agg_t       next_agg;
  logic [NDS-1:0]  ack_seen;
  logic [NDS-1:0]  fence_done; // downstream link in l2/l3 ready
  logic            us_l2rdy;

  wire logic all_acks   = &(ack_seen | ds_ack_rx | ~ds_active);
  wire logic us_d3      = (fstate[0] == PSPM_D3_HOT);
  wire logic tlp_abort  = (agg == PSPM_AG_WAIT) && us_tlp_rx;

  // aggregation sequencing
  always_comb
  begin
    next_agg = agg;
    case (agg)
      PSPM_AG_IDLE: if (us_turn_off_rx) next_agg = PSPM_AG_WAIT;
      PSPM_AG_WAIT: if (us_tlp_rx) next_agg = PSPM_AG_ABAN;
                    else if (all_acks) next_agg = PSPM_AG_DONE;
      PSPM_AG_DONE: next_agg = PSPM_AG_DONE;
      PSPM_AG_ABAN: if (us_turn_off_rx) next_agg = PSPM_AG_WAIT;
      default:      next_agg = PSPM_AG_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      agg <= PSPM_AG_IDLE;
    else
      agg <= next_agg;
  end

  // acks collected per downstream port; cleared on a new turn-off
  always_ff @(posedge clock)
  begin
    if (srst || us_turn_off_rx)
      ack_seen <= '0;
    else if (agg == PSPM_AG_WAIT)
      ack_seen <= ack_seen | (ds_ack_rx & ds_active);
  end

  // downstream links after ack stay in l2/l3 ready until traffic
  always_ff @(posedge clock)
  begin
    if (srst)
      fence_done <= '0;
    else
      fence_done <= (fence_done | ds_ack_rx) & ~(ds_tlp_tx | ds_cpl_tx);
  end

  // upstream link held in l2/l3 ready after the ack
  always_ff @(posedge clock)
  begin
    if (srst)
      us_l2rdy <= 1'b0;
    else if (agg == PSPM_AG_WAIT && !us_tlp_rx && all_acks)
      us_l2rdy <= 1'b1;
    else if (agg != PSPM_AG_DONE)
      us_l2rdy <= 1'b0;
  end

  // fence outputs
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      turn_off_tx <= '0;
      us_ack_tx   <= 1'b0;
      us_tlp_drop <= 1'b0;
      ds_retrain  <= '0;
    end
    else
    begin
      turn_off_tx <= us_turn_off_rx ? ds_active : '0;
      us_ack_tx   <= (agg == PSPM_AG_WAIT) && !us_tlp_rx && all_acks;
      us_tlp_drop <= (agg == PSPM_AG_DONE) && us_tlp_rx;
      ds_retrain  <= (tlp_abort && !us_tlp_to_self) ? (ds_tlp_tx & ~ds_link_l0) : '0;
    end
  end

  // link state requests per port
  for (gi = 0; gi <= NDS; gi++)
  begin : g_link
    wire logic in_d3 = (fstate[gi] == PSPM_D3_HOT);
    wire logic raise = err_valid[gi] && err_from_tlp[gi] && err_report_en[gi];
    wire logic need_tx;
    wire logic l2;
    if (gi == 0)
    begin : g_us
      assign need_tx = 1'b0;
      assign l2 = us_l2rdy;
    end
    else
    begin : g_ds
      assign need_tx = ds_cpl_tx[gi-1] || ds_tlp_tx[gi-1];
      assign l2 = fence_done[gi-1];
    end
    // upstream function in d3hot on a one-function port: l1 only then
    always_ff @(posedge clock)
    begin
      if (srst)
        link_req[gi] <= PSPM_L0;
      else if (raise || need_tx || (!in_d3 && !l2))
        link_req[gi] <= PSPM_L0;
      else if (l2)
        link_req[gi] <= PSPM_L2RDY;
      else
        link_req[gi] <= PSPM_L1;
    end
    // tlp errors reported; others discarded in d3hot
    always_ff @(posedge clock)
    begin
      if (srst)
        err_msg_send[gi] <= 1'b0;
      else
        err_msg_send[gi] <= err_valid[gi] && err_report_en[gi] && (!in_d3 || err_from_tlp[gi]);
    end
  end

  // downstream l1 acceptance and hot-plug pme; upstream never sends pme
  for (gi = 0; gi < NDS; gi++)
  begin : g_ds_pm
    wire logic ds_d3 = (fstate[gi+1] == PSPM_D3_HOT);
    always_ff @(posedge clock)
    begin
      if (srst)
      begin
        ds_l1_accept[gi] <= 1'b0;
        pme_send[gi]     <= 1'b0;
      end
      else
      begin
        ds_l1_accept[gi] <= ds_partner_l1_req[gi];
        pme_send[gi]     <= ds_hp_event[gi] && ds_pme_enable[gi] && (ds_d3 || us_d3);
      end
    end
  end

  // partition and device low power
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      partition_low <= 1'b0;
      device_low    <= 1'b0;
    end
    else
    begin
      partition_low <= us_d3 && (agg == PSPM_AG_DONE);
      device_low    <= (partition_low || !partition_enabled) && other_partitions_low;
    end
  end

  AST_FORWARD: assert property (@(posedge clock) disable iff (srst)
    us_turn_off_rx |=> turn_off_tx == $past(ds_active))
    else $error("turn-off not forwarded to active ports");
  AST_ACK_AFTER_ALL: assert property (@(posedge clock) disable iff (srst)
    us_ack_tx |-> $past(agg) == PSPM_AG_WAIT && $past(all_acks) && !$past(us_tlp_rx))
    else $error("upstream ack sent before all acks");
  sequence s_wait_tlp;
    agg == PSPM_AG_WAIT && us_tlp_rx;
  endsequence
  AST_ABANDON: assert property (@(posedge clock) disable iff (srst)
    s_wait_tlp |=> agg == PSPM_AG_ABAN && !us_ack_tx)
    else $error("aggregation not abandoned on tlp");
  AST_DROP: assert property (@(posedge clock) disable iff (srst)
    (agg == PSPM_AG_DONE && us_tlp_rx) |=> us_tlp_drop)
    else $error("tlp after ack not discarded");
  AST_PART_LOW: assert property (@(posedge clock) disable iff (srst)
    partition_low |-> $past(us_d3) && $past(agg) == PSPM_AG_DONE)
    else $error("partition low without d3hot and fence");
  AST_L1_ACCEPT: assert property (@(posedge clock) disable iff (srst)
    ds_partner_l1_req[0] |=> ds_l1_accept[0])
    else $error("partner l1 request refused");
  AST_NO_ERR_D3: assert property (@(posedge clock) disable iff (srst)
    (fstate[1] == PSPM_D3_HOT && err_valid[1] && !err_from_tlp[1]) |=> !err_msg_send[1])
    else $error("non-tlp error reported in d3hot");
  AST_D0_L0: assert property (@(posedge clock) disable iff (srst)
    (fstate[0] != PSPM_D3_HOT && !us_l2rdy) |=> link_req[0] == PSPM_L0)
    else $error("d0 upstream link not in l0");
  // l1 on the upstream link only follows its function in d3hot
  AST_US_L1: assert property (@(posedge clock) disable iff (srst)
    link_req[0] == PSPM_L1 |-> $past(fstate[0]) == PSPM_D3_HOT)
    else $error("upstream l1 without d3hot");
  // pending downstream traffic keeps or brings the link to l0
  AST_TX_L0: assert property (@(posedge clock) disable iff (srst)
    (ds_cpl_tx[0] || ds_tlp_tx[0]) |=> link_req[1] == PSPM_L0)
    else $error("downstream link not raised for traffic");
  // a tlp error with reporting on raises the link first
  AST_ERR_L0: assert property (@(posedge clock) disable iff (srst)
    (err_valid[1] && err_from_tlp[1] && err_report_en[1]) |=> link_req[1] == PSPM_L0)
    else $error("link not raised for error report");
  // an abandoning tlp toward a link out of l0 retrains it
  AST_RETRAIN: assert property (@(posedge clock) disable iff (srst)
    (tlp_abort && !us_tlp_to_self && ds_tlp_tx[0] && !ds_link_l0[0]) |=> ds_retrain[0])
    else $error("abandoning tlp did not retrain link");
  // a hot-plug event on a d3hot downstream port sends a pme
  AST_HP_PME: assert property (@(posedge clock) disable iff (srst)
    (ds_hp_event[0] && ds_pme_enable[0] && fstate[1] == PSPM_D3_HOT) |=> pme_send[0])
    else $error("hot-plug pme not sent from d3hot");
  // device low power needs every enabled partition low
  AST_DEV_LOW: assert property (@(posedge clock) disable iff (srst)
    device_low |-> $past(other_partitions_low) && ($past(partition_low) || !$past(partition_enabled)))
    else $error("device low power too early");

endmodule : pspm_top

// *** sim/pspm_partner.sv ***
// downstream link partners for the switch power management bench
// assumes turn-off and retrain requests arrive as one-cycle pulses on the core clock
module pspm_partner
  import pspm_pkg::*;
#(
  parameter int NDS = 2
)
(
  input  wire logic           clock,
  input  wire logic           srst,
  input  wire logic [NDS-1:0] slow,
  input  wire logic [NDS-1:0] turn_off_tx,
  input  wire logic [NDS-1:0] ds_retrain,
  output logic      [NDS-1:0] ds_ack_rx,
  output logic      [NDS-1:0] ds_link_l0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt [NDS];

  // each partner acks a turn-off after a short or long delay and leaves l0 on the same edge
  always_ff @(posedge clock)
    for (int i = 0; i < NDS; i++)
    begin
      ds_ack_rx[i] <= 1'b0;
      if (srst)
      begin
        cnt[i]        <= 4'h0;
        ds_link_l0[i] <= 1'b1;
      end
      else if (turn_off_tx[i])
        cnt[i] <= slow[i] ? 4'h6 : 4'h1;
      else if (cnt[i] == 4'h1)
      begin
        ds_ack_rx[i]  <= 1'b1;
        ds_link_l0[i] <= 1'b0;
        cnt[i]        <= 4'h0;
      end
      else if (cnt[i] != 4'h0)
        cnt[i] <= cnt[i] - 4'h1;
      if (!srst && ds_retrain[i])
        ds_link_l0[i] <= 1'b1; // back through detect to l0
    end
endmodule : pspm_partner

// *** sim/pspm_top_bench.sv ***
// self-checking bench for the switch power management block
// assumes the partner model answers every downstream turn-off
module pspm_top_bench
  import pspm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int N = 2;
  logic         clock = 1'b0;
  logic         srst = 1'b1;
  logic [N:0]   cfg_done = '0, ps_write = '0, err_valid = '0, err_from_tlp = '0, err_report_en = '0;
  logic [1:0]   ps_wdata = 2'h0;
  pspm_req_t    req [N:0];
  logic         other_low = 1'b0, us_turn_off_rx = 1'b0, us_tlp_rx = 1'b0, part_en = 1'b1;
  logic [N-1:0] ds_active = '0, ds_l1 = '0, ds_hp = '0, ds_tlp_tx = '0, slow = '0;
  pspm_fstate_t fstate [N:0];
  logic [1:0]   psf [N:0];
  logic [N:0]   nsr, err_msg;
  pspm_disp_t   disp [N:0];
  pspm_link_t   link_req [N:0];
  logic [N-1:0] l1_acc, pme, turn_off_tx, ack_rx, retrain, link_l0;
  logic         us_ack_tx, drop, part_low, dev_low;
  int           error_cnt = 0;
  int           n_tests = 0;

  pspm_top #(.NDS(N)) i_dut (.clock(clock), .srst(srst), .cfg_done(cfg_done), .ps_write(ps_write),
    .ps_wdata(ps_wdata), .req(req), .other_partitions_low(other_low), .partition_enabled(part_en),
    .ds_active(ds_active), .ds_partner_l1_req(ds_l1), .ds_hp_event(ds_hp), .ds_pme_enable(2'b11),
    .err_valid(err_valid), .err_from_tlp(err_from_tlp), .err_report_en(err_report_en), .ds_cpl_tx(2'b00),
    .ds_tlp_tx(ds_tlp_tx), .ds_link_l0(link_l0), .us_turn_off_rx(us_turn_off_rx), .ds_ack_rx(ack_rx),
    .us_tlp_rx(us_tlp_rx), .us_tlp_to_self(1'b0), .fstate(fstate), .power_state_field(psf),
    .no_soft_reset_flag(nsr), .disp(disp), .link_req(link_req), .ds_l1_accept(l1_acc),
    .err_msg_send(err_msg), .pme_send(pme), .turn_off_tx(turn_off_tx), .us_ack_tx(us_ack_tx),
    .us_tlp_drop(drop), .ds_retrain(retrain), .partition_low(part_low), .device_low(dev_low));

  pspm_partner #(.NDS(N)) i_partner (.clock(clock), .srst(srst), .slow(slow), .turn_off_tx(turn_off_tx),
    .ds_retrain(retrain), .ds_ack_rx(ack_rx), .ds_link_l0(link_l0));

  // 25 MHz core clock
  initial forever #20 clock = ~clock;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  // one edge, then let its updates land
  task automatic tick;
    @(posedge clock);
    #1;
  endtask : tick

  // one-cycle configure or power state write
  task automatic wr(input int i, input logic [1:0] code, input logic cfg);
    @(posedge clock);
    if (cfg)
      cfg_done[i] <= 1'b1;
    else
      ps_write[i] <= 1'b1;
    ps_wdata <= code;
    @(posedge clock);
    cfg_done <= '0;
    ps_write <= '0;
    #1;
  endtask : wr

  task automatic wait_link(input int i, input pspm_link_t v);
    for (int k = 0; k < 6 && link_req[i] !== v; k++)
      tick();
    chk(link_req[i], v);
    if (link_req[i] !== v)
      finish_test();
  endtask : wait_link

  task automatic t_reset;
    for (int i = 0; i <= N; i++)
    begin
      chk(fstate[i], PSPM_D0_UNINIT);
      chk(psf[i], PS_D0);
      chk(link_req[i], PSPM_L0);
    end
    chk(nsr, 8'h7);
  endtask : t_reset

  task automatic t_states;
    for (int i = 0; i <= N; i++)
    begin
      wr(i, 2'h0, 1'b1);
      chk(fstate[i], PSPM_D0_ACTIVE);
    end
    wr(1, 2'h1, 1'b0);
    chk(fstate[1], PSPM_D0_ACTIVE);
    for (int i = 1; i <= N; i++)
    begin
      wr(i, PS_D3HOT, 1'b0);
      chk(fstate[i], PSPM_D3_HOT);
      chk(psf[i], PS_D3HOT);
      wait_link(i, PSPM_L1);
    end
    chk(link_req[0], PSPM_L0);
    wr(1, 2'h2, 1'b0);
    chk(fstate[1], PSPM_D3_HOT);
    wr(2, PS_D0, 1'b0);
    chk(fstate[2], PSPM_D0_UNINIT);
    chk(nsr, 8'h7);
    wait_link(2, PSPM_L0);
    wr(2, 2'h0, 1'b1);
    wr(2, PS_D3HOT, 1'b0);
  endtask : t_states

  // request classes against a bridge in d3hot, masked disposition
  task automatic t_disp;
    logic [5:0] rq [6] = '{6'h3a, 6'h36, 6'h30, 6'h20, 6'h33, 6'h31};
    logic [3:0] mk [6] = '{4'hc, 4'hc, 4'h4, 4'h4, 4'h3, 4'h3};
    logic [3:0] ex [6] = '{4'h8, 4'h8, 4'h4, 4'h4, 4'h2, 4'h1};
    for (int k = 0; k < 6; k++)
    begin
      @(posedge clock);
      req[1] <= rq[k];
      #1;
      chk(disp[1] & mk[k], ex[k]);
    end
    @(posedge clock);
    req[1] <= '0;
  endtask : t_disp

  // a non-tlp then a tlp error, with hot-plug wake and partner l1 request off then on
  task automatic t_events;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clock);
      err_valid[1]     <= 1'b1;
      err_from_tlp[1]  <= k[0];
      err_report_en[1] <= 1'b1;
      ds_hp[0]         <= k[0];
      ds_l1[0]         <= k[0];
      @(posedge clock);
      err_valid <= '0;
      ds_hp     <= '0;
      ds_l1     <= '0;
      #1;
      chk(err_msg[1], k[0]);
      chk(pme[0], k[0]);
      chk(l1_acc[0], k[0]);
    end
  endtask : t_events

  // turn-off fence, abandoned by a tlp or carried to completion
  task automatic t_fence(input logic ab);
    int   k;
    logic seen;
    seen = 1'b0;
    @(posedge clock);
    ds_active      <= ab ? 2'b11 : 2'b10;
    slow           <= 2'b10;
    us_turn_off_rx <= 1'b1;
    @(posedge clock);
    us_turn_off_rx <= 1'b0;
    #1;
    chk(turn_off_tx, ds_active);
    if (ab)
    begin
      for (k = 0; k < 8 && link_l0[0]; k++)
        tick();
      chk(link_l0[0], 1'b0);
      @(posedge clock);
      us_tlp_rx <= 1'b1;
      ds_tlp_tx <= 2'b01;
      @(posedge clock);
      us_tlp_rx <= 1'b0;
      ds_tlp_tx <= 2'b00;
      #1;
      chk(retrain[0], 1'b1);
      for (k = 0; k < 12; k++)
      begin
        tick();
        seen |= us_ack_tx;
      end
      chk(seen, 1'b0);
      chk(part_low, 1'b0);
      chk(link_l0[0], 1'b1);
    end
    else
    begin
      for (k = 0; k < 20 && us_ack_tx !== 1'b1; k++)
      begin
        tick();
        seen |= ack_rx[1];
      end
      chk(us_ack_tx, 1'b1);
      chk(seen, 1'b1);
      if (us_ack_tx !== 1'b1)
        finish_test();
      tick();
      chk(part_low, 1'b1);
      chk(link_req[0], PSPM_L2RDY);
      chk(dev_low, 1'b0);
      @(posedge clock);
      other_low <= 1'b1;
      us_tlp_rx <= 1'b1;
      @(posedge clock);
      us_tlp_rx <= 1'b0;
      #1;
      chk(dev_low, 1'b1);
      chk(drop, 1'b1);
    end
  endtask : t_fence

  // a disabled partition does not hold the device out of low power
  task automatic t_disabled;
    chk(dev_low, 1'b0);
    @(posedge clock);
    part_en <= 1'b0;
    tick();
    chk(dev_low, 1'b1);
  endtask : t_disabled

  // main sequence
  initial
  begin
    foreach (req[i])
      req[i] = '0;
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    tick();
    t_reset();
    t_states();
    t_disp();
    t_events();
    wr(0, PS_D3HOT, 1'b0);
    wait_link(0, PSPM_L1);
    t_fence(1'b1);
    t_fence(1'b0);
    @(posedge clock);
    srst <= 1'b1;
    @(posedge clock);
    srst <= 1'b0;
    tick();
    t_reset();
    t_disabled();
    finish_test();
  end
endmodule : pspm_top_bench
